// ==== ssr_pkg.sv ====
// Package with constants and types of the global setup register block
package ssr_pkg;

  // ==========================================================================
  // Register map
  // ==========================================================================
  localparam int          ADDR_W          = 6;
  localparam int          DATA_W          = 16;
  localparam logic [5:0]  GSR_OFFSET      = 6'h02;
  localparam logic [15:0] GSR_RESET       = 16'h0000;
  // Writable positions: 13-12, 10-9, 8-6, 5, 2-0
  localparam logic [15:0] GSR_WRITE_MASK  = 16'h37E7;
  localparam logic [15:0] RDATA_IDLE      = 16'h0000;

  // ==========================================================================
  // Field positions
  // ==========================================================================
  localparam int          DIAGNOSTIC_RUN_SELECT_LSB    = 12;
  localparam int          TRIG_SRC_LSB    = 9;
  localparam int          READ_FMT_LSB    = 6;
  localparam int          ANA_DIAG_BIT    = 5;
  localparam int          Z_LIM_BIT       = 2;
  localparam int          Y_LIM_BIT       = 1;
  localparam int          X_LIM_BIT       = 0;

  // Operating states in which a trigger is honoured, one bit per code
  localparam logic [7:0]  TRIG_STATE_MASK = 8'h02;
  localparam int          OP_STATE_W      = 3;

  // ==========================================================================
  // Field encodings
  // ==========================================================================
  typedef enum logic [1:0] {
    DIAG_ALL_TOGETHER,
    DIAG_ENABLED_TOGETHER,
    DIAG_ALL_SEQUENCE,
    DIAG_ENABLED_SEQUENCE
  } ssr_diag_run_t;

  typedef enum logic [1:0] {
    TRIG_SPI_CMD,
    TRIG_CS_PULSE,
    TRIG_ALERT_PULSE,
    TRIG_UNUSED
  } ssr_trig_src_t;

  typedef enum logic [2:0] {
    FMT_WORD32,
    FMT_PAIR_XY,
    FMT_PAIR_XZ,
    FMT_PAIR_ZY,
    FMT_PAIR_XT,
    FMT_PAIR_YT,
    FMT_PAIR_ZT,
    FMT_PAIR_AM
  } ssr_read_fmt_t;

  // Register image, bit for bit
  typedef struct packed {
    logic [1:0]    rsv_15_14;
    ssr_diag_run_t diagnostic_run_select;
    logic          rsv_11;
    ssr_trig_src_t trigger_source;
    ssr_read_fmt_t read_format;
    logic          analog_diag_enable;
    logic [1:0]    rsv_4_3;
    logic          z_limit_check_enable;
    logic          y_limit_check_enable;
    logic          x_limit_check_enable;
  } ssr_cfg_t;

  // Trigger events, one bit per source
  typedef struct packed {
    logic spi_cmd;
    logic cs_pulse;
    logic alert_pulse;
  } ssr_trig_evt_t;

endpackage : ssr_pkg

// ==== ssr_trig_arb.sv ====
// Trigger arbiter: holds one pending trigger and launches one conversion
`timescale 1ns/1ns
module ssr_trig_arb (
  mclk,
  rst_n,
  trig_event,
  conv_busy,
  conv_done,
  conv_start,
  trig_pending,
  trig_dropped
);
  input  wire logic mclk;
  input  wire logic rst_n;
  input  wire logic trig_event;
  input  wire logic conv_busy;
  input  wire logic conv_done;
  output wire logic conv_start;
  output wire logic trig_pending;
  output wire logic trig_dropped;

  typedef enum logic [1:0] {
    ARB_IDLE,
    ARB_PEND,
    ARB_EXEC
  } ssr_arb_state_t;

  typedef struct packed {
    ssr_arb_state_t state;
    logic           start;
    logic           dropped;
  } ssr_arb_t;

  ssr_arb_t arb_reg;
  ssr_arb_t arb_next;

  // ==========================================================================
  // Next state
  // ==========================================================================
  always_comb begin
    arb_next         = arb_reg;
    arb_next.start   = 1'b0;
    arb_next.dropped = 1'b0;
    case (arb_reg.state)
      ARB_IDLE: begin
        if (trig_event) begin
          arb_next.state = ARB_PEND;
        end
      end
      ARB_PEND: begin
        // A running conversion is finished first
        if (!conv_busy) begin
          arb_next.start = 1'b1;
          arb_next.state = ARB_EXEC;
        end
        arb_next.dropped = trig_event;
      end
      ARB_EXEC: begin
        // Waits on done, not busy, so a late busy rise is harmless
        if (conv_done) begin
          arb_next.state = ARB_IDLE;
        end
        arb_next.dropped = trig_event;
      end
      default: begin
        arb_next.state = ARB_IDLE;
      end
    endcase
  end

  // Register
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      arb_reg <= '{state: ARB_IDLE, start: 1'b0, dropped: 1'b0};
    end else begin
      arb_reg <= arb_next;
    end
  end

  assign conv_start   = arb_reg.start;
  assign trig_pending = (arb_reg.state != ARB_IDLE);
  assign trig_dropped = arb_reg.dropped;

endmodule // ssr_trig_arb

// ==== ssr_setup_reg.sv ====
// Global setup register: diagnostics, trigger source, read format, limits
`timescale 1ns/1ns
module ssr_setup_reg (
  mclk,
  rst_n,
  reg_addr,
  reg_wr_en,
  reg_wdata,
  reg_rd_en,
  reg_rdata,
  reg_hit,
  trig_events,
  operating_state_select,
  alert_switch_mode,
  conv_busy,
  conv_done,
  conv_start,
  trig_pending,
  trig_dropped,
  diagnostic_run_select,
  diag_enabled_only,
  diag_in_sequence,
  analog_diag_enable,
  trigger_source,
  read_format,
  read_word32,
  read_pair_second_temp,
  x_limit_check_enable,
  y_limit_check_enable,
  z_limit_check_enable,
  switch_axes_missing
);
  parameter int ADDR_W = ssr_pkg::ADDR_W;
  parameter int DATA_W = ssr_pkg::DATA_W;

  input  wire logic                  mclk;
  input  wire logic                  rst_n;
  input  wire logic [ADDR_W-1:0]     reg_addr;
  input  wire logic                  reg_wr_en;
  input  wire logic [DATA_W-1:0]     reg_wdata;
  input  wire logic                  reg_rd_en;
  output wire logic [DATA_W-1:0]     reg_rdata;
  output wire logic                  reg_hit;
  input  wire ssr_pkg::ssr_trig_evt_t trig_events;
  input  wire logic [ssr_pkg::OP_STATE_W-1:0] operating_state_select;
  input  wire logic                  alert_switch_mode;
  input  wire logic                  conv_busy;
  input  wire logic                  conv_done;
  output wire logic                  conv_start;
  output wire logic                  trig_pending;
  output wire logic                  trig_dropped;
  output wire ssr_pkg::ssr_diag_run_t diagnostic_run_select;
  output wire logic                  diag_enabled_only;
  output wire logic                  diag_in_sequence;
  output wire logic                  analog_diag_enable;
  output wire ssr_pkg::ssr_trig_src_t trigger_source;
  output wire ssr_pkg::ssr_read_fmt_t read_format;
  output wire logic                  read_word32;
  output wire logic                  read_pair_second_temp;
  output wire logic                  x_limit_check_enable;
  output wire logic                  y_limit_check_enable;
  output wire logic                  z_limit_check_enable;
  output wire logic                  switch_axes_missing;

  // ==========================================================================
  // Helper functions
  // ==========================================================================

  // Address compare, used for both read and write paths
  function automatic logic addr_match(input logic [ADDR_W-1:0] a);
    addr_match = (a == ADDR_W'(ssr_pkg::GSR_OFFSET));
  endfunction

  // Clean a write: reserved positions dropped, unused trigger code folded
  function automatic ssr_pkg::ssr_cfg_t clean_write(input logic [DATA_W-1:0] d);
    ssr_pkg::ssr_cfg_t c;
    c = ssr_pkg::ssr_cfg_t'(d[15:0] & ssr_pkg::GSR_WRITE_MASK);
    if (c.trigger_source == ssr_pkg::TRIG_UNUSED) begin
      c.trigger_source = ssr_pkg::TRIG_SPI_CMD;
    end
    clean_write = c;
  endfunction

  // Operating state lookup in the designated-state mask
  function automatic logic state_allows(input logic [ssr_pkg::OP_STATE_W-1:0] s);
    state_allows = ssr_pkg::TRIG_STATE_MASK[s];
  endfunction

  // ==========================================================================
  // State
  // ==========================================================================
  typedef struct packed {
    ssr_pkg::ssr_cfg_t cfg;
    logic [DATA_W-1:0] rdata;
    logic              hit;
    logic              evt;
    logic              enabled_only;
    logic              in_sequence;
    logic              word32;
    logic              second_temp;
    logic              axes_missing;
  } ssr_top_t;

  ssr_top_t st_reg;
  ssr_top_t st_next;

  logic             arb_start;
  logic             arb_pending;
  logic             arb_dropped;

  // ==========================================================================
  // Next-state logic
  // ==========================================================================
  always_comb begin
    logic sel_evt;
    logic wr_hit;
    sel_evt = 1'b0;
    wr_hit  = reg_wr_en && addr_match(reg_addr);
    st_next = st_reg;

    // Register write; reserved fields never take data
    if (wr_hit) begin
      st_next.cfg = clean_write(reg_wdata);
    end

    // Read answer, registered; unmapped address returns zero
    st_next.hit = reg_rd_en && addr_match(reg_addr);
    if (reg_rd_en && addr_match(reg_addr)) begin
      st_next.rdata = DATA_W'(st_reg.cfg);
    end else if (reg_rd_en) begin
      st_next.rdata = DATA_W'(ssr_pkg::RDATA_IDLE);
    end

    // Trigger source select
    case (st_reg.cfg.trigger_source)
      ssr_pkg::TRIG_SPI_CMD: begin
        sel_evt = trig_events.spi_cmd;
      end
      ssr_pkg::TRIG_CS_PULSE: begin
        sel_evt = trig_events.cs_pulse;
      end
      ssr_pkg::TRIG_ALERT_PULSE: begin
        // Switch mode owns the pin, so its pulses are not triggers
        sel_evt = trig_events.alert_pulse && !alert_switch_mode;
      end
      default: begin
        sel_evt = trig_events.spi_cmd;
      end
    endcase
    // Outside designated operating states the event is dropped
    st_next.evt = sel_evt && state_allows(operating_state_select);

    // Diagnostic run decode
    st_next.enabled_only =
      (st_reg.cfg.diagnostic_run_select == ssr_pkg::DIAG_ENABLED_TOGETHER) ||
      (st_reg.cfg.diagnostic_run_select == ssr_pkg::DIAG_ENABLED_SEQUENCE);
    st_next.in_sequence =
      (st_reg.cfg.diagnostic_run_select == ssr_pkg::DIAG_ALL_SEQUENCE) ||
      (st_reg.cfg.diagnostic_run_select == ssr_pkg::DIAG_ENABLED_SEQUENCE);

    // Read format decode: full word or a 12-bit pair
    st_next.word32      = (st_reg.cfg.read_format == ssr_pkg::FMT_WORD32);
    st_next.second_temp =
      (st_reg.cfg.read_format == ssr_pkg::FMT_PAIR_XT) ||
      (st_reg.cfg.read_format == ssr_pkg::FMT_PAIR_YT) ||
      (st_reg.cfg.read_format == ssr_pkg::FMT_PAIR_ZT);

    // Flag switch mode with no axis check enabled; controller's duty
    st_next.axes_missing = alert_switch_mode &&
      !(st_reg.cfg.x_limit_check_enable ||
        st_reg.cfg.y_limit_check_enable ||
        st_reg.cfg.z_limit_check_enable);
  end

  // ==========================================================================
  // Registers
  // ==========================================================================
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st_reg.cfg          <= ssr_pkg::ssr_cfg_t'(ssr_pkg::GSR_RESET);
      st_reg.rdata        <= DATA_W'(ssr_pkg::RDATA_IDLE);
      st_reg.hit          <= 1'b0;
      st_reg.evt          <= 1'b0;
      st_reg.enabled_only <= 1'b0;
      st_reg.in_sequence  <= 1'b0;
      st_reg.word32       <= 1'b1;
      st_reg.second_temp  <= 1'b0;
      st_reg.axes_missing <= 1'b0;
    end else begin
      st_reg <= st_next;
    end
  end

  // ==========================================================================
  // Trigger arbitration
  // ==========================================================================
  // One pending slot only; extra events are flagged on trig_dropped
  ssr_trig_arb u_arb (
    .mclk         (mclk),
    .rst_n        (rst_n),
    .trig_event   (st_reg.evt),
    .conv_busy    (conv_busy),
    .conv_done    (conv_done),
    .conv_start   (arb_start),
    .trig_pending (arb_pending),
    .trig_dropped (arb_dropped)
  );

  // ==========================================================================
  // Outputs
  // ==========================================================================
  assign reg_rdata             = st_reg.rdata;
  assign reg_hit               = st_reg.hit;
  assign conv_start            = arb_start;
  assign trig_pending          = arb_pending;
  assign trig_dropped          = arb_dropped;
  assign diagnostic_run_select = st_reg.cfg.diagnostic_run_select;
  assign diag_enabled_only     = st_reg.enabled_only;
  assign diag_in_sequence      = st_reg.in_sequence;
  // Clear bit forbids analog front-end tests
  assign analog_diag_enable    = st_reg.cfg.analog_diag_enable;
  assign trigger_source        = st_reg.cfg.trigger_source;
  assign read_format           = st_reg.cfg.read_format;
  assign read_word32           = st_reg.word32;
  assign read_pair_second_temp = st_reg.second_temp;
  assign x_limit_check_enable  = st_reg.cfg.x_limit_check_enable;
  assign y_limit_check_enable  = st_reg.cfg.y_limit_check_enable;
  assign z_limit_check_enable  = st_reg.cfg.z_limit_check_enable;
  assign switch_axes_missing   = st_reg.axes_missing;

endmodule // ssr_setup_reg

// ==== ssr_setup_reg_chk.sv ====
// Checker of the global setup register block, port side only
`timescale 1ns/1ns
module ssr_setup_reg_chk (
  input wire logic                   mclk,
  input wire logic                   rst_n,
  input wire logic [5:0]             reg_addr,
  input wire logic                   reg_wr_en,
  input wire logic [15:0]            reg_wdata,
  input wire logic                   reg_rd_en,
  input wire logic [15:0]            reg_rdata,
  input wire logic                   reg_hit,
  input wire logic [2:0]             operating_state_select,
  input wire logic                   conv_busy,
  input wire logic                   conv_start,
  input wire logic                   trig_pending,
  input wire logic                   trig_dropped,
  input wire ssr_pkg::ssr_diag_run_t diagnostic_run_select,
  input wire ssr_pkg::ssr_trig_src_t trigger_source,
  input wire ssr_pkg::ssr_read_fmt_t read_format,
  input wire logic                   read_word32,
  input wire logic                   x_limit_check_enable
);
  // ==========================================================================
  // Register port
  // ==========================================================================
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);

  AST_RD_HIT: assert property (reg_rd_en && reg_addr == 6'h02 |=> reg_hit)
    else $error("setup word read not acknowledged");
  AST_MISS: assert property (reg_rd_en && reg_addr != 6'h02 |=> !reg_hit && reg_rdata == 16'h0000)
    else $error("unmapped read returned data or hit");
  AST_RSV: assert property (reg_rd_en |=> (reg_rdata & 16'hC818) == 16'h0000)
    else $error("reserved bits read nonzero");
  AST_WR: assert property (reg_wr_en && reg_addr == 6'h02 |=>
    diagnostic_run_select == $past(reg_wdata[13:12]) && read_format == $past(reg_wdata[8:6])
    && x_limit_check_enable == $past(reg_wdata[0]))
    else $error("written fields not visible");
  AST_TRIG3: assert property (reg_wr_en && reg_addr == 6'h02 && reg_wdata[10:9] == 2'h3
    |=> trigger_source == ssr_pkg::TRIG_SPI_CMD)
    else $error("unused trigger code not folded to zero");
  AST_FMT: assert property (read_word32 == ($past(read_format) == ssr_pkg::FMT_WORD32))
    else $error("word format decode wrong");

  // ==========================================================================
  // Trigger arbiter
  // ==========================================================================
  AST_BUSY: assert property (conv_start |-> $past(trig_pending) && !$past(conv_busy))
    else $error("start while engine busy");
  AST_ONE: assert property (conv_start |=> !conv_start [*3])
    else $error("extra conversion start");
  AST_DROP: assert property (trig_dropped |-> $past(trig_pending))
    else $error("drop without pending trigger");
  AST_STATE: assert property ($rose(trig_pending) |-> $past(operating_state_select, 2) == 3'h1)
    else $error("trigger taken in wrong state");
endmodule // ssr_setup_reg_chk

// ==== ssr_conv_model.sv ====
// Behavioural conversion engine answering start pulses
`timescale 1ns/1ns
module ssr_conv_model #(
  parameter int LAT = 6
) (
  input  wire logic mclk,
  input  wire logic rst_n,
  input  wire logic conv_start,
  output logic      conv_busy,
  output logic      conv_done
);
  int cnt;
  // Busy for LAT cycles per start, then one done pulse; slow enough to overlap triggers
  always @(posedge mclk) begin
    conv_done <= 1'b0;
    if (!rst_n) begin
      conv_busy <= 1'b0;
      cnt       <= 0;
    end else if (conv_start) begin
      conv_busy <= 1'b1;
      cnt       <= LAT;
    end else if (cnt == 1) begin
      conv_busy <= 1'b0;
      conv_done <= 1'b1;
      cnt       <= 0;
    end else if (cnt > 1) begin
      cnt <= cnt - 1;
    end
  end
endmodule // ssr_conv_model

// ==== tb.sv ====
// Self-checking testbench of the global setup register block
`timescale 1ns/1ns
module tb;
  logic                   mclk = 1'b0;
  logic                   rst_n = 1'b0;
  logic [5:0]             reg_addr = 6'h00;
  logic                   reg_wr_en = 1'b0;
  logic                   reg_rd_en = 1'b0;
  logic [15:0]            reg_wdata = 16'h0000;
  ssr_pkg::ssr_trig_evt_t trig_events = 3'h0;
  logic [2:0]             operating_state_select = 3'h1;
  logic                   alert_switch_mode = 1'b0;
  wire logic [15:0]       reg_rdata;
  wire logic reg_hit, conv_busy, conv_done, conv_start, trig_pending, trig_dropped;
  wire logic diag_enabled_only, diag_in_sequence, analog_diag_enable, read_word32;
  wire logic read_pair_second_temp, x_limit_check_enable, y_limit_check_enable;
  wire logic z_limit_check_enable, switch_axes_missing;
  wire ssr_pkg::ssr_diag_run_t diagnostic_run_select;
  wire ssr_pkg::ssr_trig_src_t trigger_source;
  wire ssr_pkg::ssr_read_fmt_t read_format;
  int errors = 0, total_checks = 0, starts = 0, drops = 0;

  // 100 ns clock
  always #50 mclk = ~mclk;
  // Tally starts and drops; counting beats sampling one-cycle pulses by hand
  always @(posedge mclk) begin
    if (conv_start === 1'b1) starts++;
    if (trig_dropped === 1'b1) drops++;
  end

  ssr_setup_reg uut (.mclk, .rst_n, .reg_addr, .reg_wr_en, .reg_wdata, .reg_rd_en, .reg_rdata,
    .reg_hit, .trig_events, .operating_state_select, .alert_switch_mode, .conv_busy, .conv_done,
    .conv_start, .trig_pending, .trig_dropped, .diagnostic_run_select, .diag_enabled_only,
    .diag_in_sequence, .analog_diag_enable, .trigger_source, .read_format, .read_word32,
    .read_pair_second_temp, .x_limit_check_enable, .y_limit_check_enable,
    .z_limit_check_enable, .switch_axes_missing);
  ssr_conv_model #(.LAT(6)) u_conv (.mclk, .rst_n, .conv_start, .conv_busy, .conv_done);

  // ==========================================================================
  // Shared tasks
  // ==========================================================================
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic check1(input logic seen, input logic exp);
    check({15'h0000, seen}, {15'h0000, exp});
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    reg_addr  = a;
    reg_wdata = d;
    reg_wr_en = 1'b1;
    cyc(1);
    reg_wr_en = 1'b0;
    // Idle edge so a following call never re-raises the strobe at once
    cyc(1);
  endtask
  task automatic rd(input logic [5:0] a, input logic [15:0] exp, input logic hit);
    reg_addr  = a;
    reg_rd_en = 1'b1;
    cyc(1);
    reg_rd_en = 1'b0;
    check(reg_rdata, exp);
    check1(reg_hit, hit);
    cyc(1);
  endtask
  task automatic evt(input logic [2:0] e);
    trig_events = e;
    cyc(1);
    trig_events = 3'h0;
    cyc(1);
  endtask
  task automatic report_and_stop();
    if (errors == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // ==========================================================================
  // Scenarios
  // ==========================================================================
  // Every code of every field, decodes checked four cycles after the write
  task automatic t_codes();
    logic [15:0] d;
    for (int i = 0; i < 8; i++) begin
      d = {2'b00, i[1:0], 1'b0, i[1:0], i[2:0], i[0], 2'b00, i[2:0]};
      wr(6'h02, d);
      cyc(1);
      if (i[1:0] == 2'h3) d[10:9] = 2'h0;
      rd(6'h02, d, 1'b1);
      check1(diag_enabled_only, i[0]);
      check1(diag_in_sequence, i[1]);
      check1(analog_diag_enable, i[0]);
      check1(read_word32, i == 0);
      check1(read_pair_second_temp, i >= 4 && i <= 6);
    end
  endtask
  // All ones, then a stray write elsewhere that must not land
  task automatic t_mask();
    wr(6'h02, 16'hFFFF);
    wr(6'h03, 16'h0000);
    rd(6'h02, 16'h31E7, 1'b1);
    check({13'h0000, z_limit_check_enable, y_limit_check_enable, x_limit_check_enable},
      16'h0007);
    rd(6'h03, 16'h0000, 1'b0);
  endtask
  // One start for the first trigger; events while pending are dropped
  task automatic t_trig();
    wr(6'h02, 16'h0000);
    evt(3'b100);
    cyc(1);
    check1(conv_start, 1'b1);
    evt(3'b100);
    evt(3'b100);
    cyc(12);
    check(starts[15:0], 16'h0001);
    check(drops[15:0], 16'h0002);
    check1(trig_pending, 1'b0);
  endtask
  // Wrong state, wrong source, and switch mode all ignore the event
  task automatic t_gate();
    operating_state_select = 3'h0;
    evt(3'b100);
    cyc(6);
    check(starts[15:0], 16'h0001);
    operating_state_select = 3'h1;
    wr(6'h02, 16'h0200);
    evt(3'b100);
    evt(3'b010);
    cyc(12);
    check(starts[15:0], 16'h0002);
    alert_switch_mode = 1'b1;
    cyc(2);
    check1(switch_axes_missing, 1'b1);
    wr(6'h02, 16'h0407);
    cyc(1);
    check1(switch_axes_missing, 1'b0);
    evt(3'b001);
    cyc(6);
    check(starts[15:0], 16'h0002);
    alert_switch_mode = 1'b0;
    evt(3'b001);
    cyc(12);
    check(starts[15:0], 16'h0003);
  endtask

  // Hang guard, far beyond the roughly 130 cycles the run needs
  initial begin
    #1000000;
    errors++;
    report_and_stop();
  end

  initial begin
    cyc(4);
    rst_n = 1'b1;
    rd(6'h02, 16'h0000, 1'b1);
    check1(read_word32, 1'b1);
    t_codes();
    t_mask();
    t_trig();
    t_gate();
    rst_n = 1'b0;
    cyc(2);
    rst_n = 1'b1;
    rd(6'h02, 16'h0000, 1'b1);
    report_and_stop();
  end
endmodule // tb

bind ssr_setup_reg ssr_setup_reg_chk u_chk (.mclk, .rst_n, .reg_addr, .reg_wr_en, .reg_wdata,
  .reg_rd_en, .reg_rdata, .reg_hit, .operating_state_select, .conv_busy, .conv_start,
  .trig_pending, .trig_dropped, .diagnostic_run_select, .trigger_source, .read_format,
  .read_word32, .x_limit_check_enable);
